// >>> core/strap_pkg.sv
// Package with strap indices, reset values and the strap bundle type.
package strap_pkg;

  // Number of functional straps caught at power-good.
  localparam int unsigned STRAP_COUNT = 3;

  // Bit position of each strap in the pin vector.
  localparam int unsigned SEC_OVR_BIT = 0;
  localparam int unsigned PORT_B_BIT = 1;
  localparam int unsigned PORT_C_BIT = 2;

  // Default of every strap: the weak pull-down makes it read as zero.
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // Reset state of the pull-down enables: all on, so straps read zero.
  localparam logic [2:0] PULLDOWN_RESET = 3'h7;

  // Latched strap values as handed to the chipset logic.
  typedef struct packed {
    logic port_c_detected;
    logic port_b_detected;
    logic security_override;
  } strap_val_t;

  // Management engine control derived from the straps.
  typedef struct packed {
    logic halt_after_bringup;
    logic runtime_disable;
  } engine_ctl_t;

endpackage

// >>> core/strap_sync.sv
// Two flip-flop synchroniser for a vector of pin levels.
module strap_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Refuse a vector with no bits when the design is elaborated.
  if (WIDTH < 1) begin : g_width_check
    $error("strap_sync needs WIDTH of at least one.");
  end

  // The first stage is read only by the second stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// >>> core/power_good_strap_latch.sv
// Power-good strap latch for descriptor override and display detection.
// Function
// - Latch security override strap at power-good rise.
// - Override high halts engine, disables runtime features.
// - Latch port B detect strap at power-good rise.
// - Latch port C detect strap at power-good rise.
// - Pull-downs enabled during reset and while power-good low.
module power_good_strap_latch (
  input wire logic clk,
  input wire logic srst,
  input wire logic primary_power_good,
  input wire logic audio_serial_out_pin,
  input wire logic port_b_control_data_pin,
  input wire logic port_c_control_data_pin,
  output logic [strap_pkg::STRAP_COUNT-1:0] pulldown_en,
  output strap_pkg::strap_val_t straps,
  output strap_pkg::engine_ctl_t management_engine,
  output logic straps_valid
);
  import strap_pkg::*;

  localparam int unsigned SYNC_W = STRAP_COUNT + 1;

  // The bundle has one field per strap, so any other count cannot be
  // served without reworking the struct as well.
  if ($bits(strap_val_t) != STRAP_COUNT) begin : g_count_check
    $error("Strap count does not match the strap bundle.");
  end

  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync_in;
  logic pwrok_s;
  logic pwrok_prev_q;
  logic pwrok_rise;
  logic [STRAP_COUNT-1:0] pins_s;
  strap_val_t straps_q;
  logic valid_q;
  logic [STRAP_COUNT-1:0] pd_q;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.

  // Power-good and straps share one synchroniser so they stay aligned.
  assign raw_in[SEC_OVR_BIT] = audio_serial_out_pin;
  assign raw_in[PORT_B_BIT] = port_b_control_data_pin;
  assign raw_in[PORT_C_BIT] = port_c_control_data_pin;
  assign raw_in[STRAP_COUNT] = primary_power_good;

  strap_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign pwrok_s = sync_in[STRAP_COUNT];
  assign pins_s = sync_in[STRAP_COUNT-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Power-good edge detection.

  // Previous level is kept low at reset, so a high level after reset
  // counts as a rise and the straps are still caught.
  always_ff @(posedge clk) begin
    if (srst) begin
      pwrok_prev_q <= 1'b0;
    end else begin
      pwrok_prev_q <= pwrok_s;
    end
  end

  assign pwrok_rise = pwrok_s & ~pwrok_prev_q;

  //////////////////////////////////////////////////////////////////////////
  // Strap capture.

  // Values change only on a rise, so later pin toggling is ignored.
  always_ff @(posedge clk) begin
    if (srst) begin
      straps_q <= strap_val_t'(STRAP_RESET);
    end else if (pwrok_rise) begin
      straps_q.security_override <= pins_s[SEC_OVR_BIT];
      straps_q.port_b_detected <= pins_s[PORT_B_BIT];
      straps_q.port_c_detected <= pins_s[PORT_C_BIT];
    end
  end

  // Valid marks that at least one capture happened since reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      valid_q <= 1'b0;
    end else if (pwrok_rise) begin
      valid_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pull-down control.

  // Enabled while synchronised power-good is low; the strap is sampled
  // on the same edge the pull-down turns off, so it still sees its
  // default. The board is trusted to pull the override up only in a
  // debug setup, so no lockout is provided.
  always_ff @(posedge clk) begin
    if (srst) begin
      pd_q <= PULLDOWN_RESET;
    end else begin
      pd_q <= {STRAP_COUNT{~pwrok_s}};
    end
  end

  assign pulldown_en = pd_q;
  assign straps = straps_q;
  assign straps_valid = valid_q;

  // A latched override is a debug mode: halt and disable the engine.
  assign management_engine.halt_after_bringup =
    straps_q.security_override;
  assign management_engine.runtime_disable =
    straps_q.security_override;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_rise;
    pwrok_s && !pwrok_prev_q;
  endsequence

  sequence s_no_rise;
    !(pwrok_s && !pwrok_prev_q);
  endsequence

  property p_sec_latch;
    @(posedge clk) disable iff (srst)
      s_rise |=> straps_q.security_override == $past(pins_s[SEC_OVR_BIT]);
  endproperty
  a_sec_latch: assert property (p_sec_latch)
    else $error("Override strap not latched on power-good rise.");

  property p_engine;
    @(posedge clk) disable iff (srst)
      management_engine.halt_after_bringup == straps_q.security_override &&
      management_engine.runtime_disable == straps_q.security_override;
  endproperty
  a_engine: assert property (p_engine)
    else $error("Engine control does not follow override strap.");

  property p_port_b;
    @(posedge clk) disable iff (srst)
      s_rise |=> straps_q.port_b_detected == $past(pins_s[PORT_B_BIT]);
  endproperty
  a_port_b: assert property (p_port_b)
    else $error("Port B strap not latched on power-good rise.");

  property p_port_c;
    @(posedge clk) disable iff (srst)
      s_rise |=> straps_q.port_c_detected == $past(pins_s[PORT_C_BIT]);
  endproperty
  a_port_c: assert property (p_port_c)
    else $error("Port C strap not latched on power-good rise.");

  property p_pd_low;
    @(posedge clk) disable iff (srst)
      !pwrok_s |=> pulldown_en == '1;
  endproperty
  a_pd_low: assert property (p_pd_low)
    else $error("Pull-down off while power-good low.");

  property p_pd_high;
    @(posedge clk) disable iff (srst)
      pwrok_s [*2] |-> pulldown_en == '0;
  endproperty
  a_pd_high: assert property (p_pd_high)
    else $error("Pull-down still on after power-good high.");

  property p_hold;
    @(posedge clk) disable iff (srst)
      s_no_rise |=> $stable(straps_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Straps changed without power-good rise.");

  property p_valid;
    @(posedge clk) disable iff (srst)
      s_rise |=> straps_valid ##1 straps_valid;
  endproperty
  a_valid: assert property (p_valid)
    else $error("Valid not held after capture.");

  // Reset forces every default whatever the pins and power-good show.
  property p_reset_vals;
    @(posedge clk)
      srst |=> pulldown_en == PULLDOWN_RESET &&
        straps_q == strap_val_t'(STRAP_RESET) && !straps_valid;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("Outputs not at defaults after reset.");

  // Valid cannot appear without a capture behind it.
  property p_valid_low;
    @(posedge clk) disable iff (srst)
      s_no_rise ##0 !straps_valid |=> !straps_valid;
  endproperty
  a_valid_low: assert property (p_valid_low)
    else $error("Valid rose without power-good rise.");

  // Once set, valid stays until the next reset.
  property p_valid_hold;
    @(posedge clk) disable iff (srst)
      straps_valid |=> straps_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("Valid dropped without reset.");

  // The engine controls move only with a fresh capture.
  property p_engine_hold;
    @(posedge clk) disable iff (srst)
      s_no_rise |=> $stable(management_engine);
  endproperty
  a_engine_hold: assert property (p_engine_hold)
    else $error("Engine control changed without power-good rise.");

endmodule

// >>> sim/strap_board.sv
// Board strap resistors on the three multiplexed strap pins.
module strap_board (
  input wire logic clk,
  input wire logic [2:0] pullup_fit,
  input wire logic [2:0] pulldown_en,
  output logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] float_q = 3'h0;
  ////////////////////////////////////////////////////////////////////////
  // A bare pin wanders, so a late sample never finds a stale level.
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  // An external pull-up overrides the weak on-chip pull-down.
  assign pins = pullup_fit | (~pulldown_en & float_q);
endmodule

// >>> sim/tb.sv
// Self-checking bench for the power-good strap latch.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic pwr_good = 1'b0;
  logic [2:0] pullup_fit = 3'h0;
  logic [2:0] last_fit = 3'h0;
  logic [2:0] pins;
  logic [2:0] pulldown_en;
  strap_val_t straps;
  engine_ctl_t engine;
  logic straps_valid;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  initial begin
    forever #2.5 clk = ~clk;
  end
  strap_board board (.clk(clk), .pullup_fit(pullup_fit),
    .pulldown_en(pulldown_en), .pins(pins));
  power_good_strap_latch dut (.clk(clk), .srst(srst),
    .primary_power_good(pwr_good), .audio_serial_out_pin(pins[0]),
    .port_b_control_data_pin(pins[1]), .port_c_control_data_pin(pins[2]),
    .pulldown_en(pulldown_en), .straps(straps),
    .management_engine(engine), .straps_valid(straps_valid));
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compares one value with its expectation and counts the outcome.
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The whole run needs about 300 cycles; a hang stops well after.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Reset leaves the pull-downs on and nothing latched.
  task automatic t_reset();
    check(pulldown_en, 3'h7);
    check(straps, STRAP_RESET);
    check({1'b0, engine}, 3'h0);
    check({2'h0, straps_valid}, 3'h0);
  endtask
  // Power-good drops and rises again with a new board fitting.
  task automatic t_capture(input logic [2:0] fit);
    pwr_good = 1'b0;
    repeat (4) @(negedge clk);
    check(pulldown_en, 3'h7);
    check(straps, last_fit);
    pullup_fit = fit;
    repeat (3) @(negedge clk);
    pwr_good = 1'b1;
    repeat (4) @(negedge clk);
    check(straps, fit);
    check({1'b0, engine}, {1'b0, fit[0], fit[0]});
    check(pulldown_en, 3'h0);
    check({2'h0, straps_valid}, 3'h1);
    last_fit = fit;
  endtask
  // Reset in mid-run with power-good high recaptures after release.
  task automatic t_reset_high(input logic [2:0] fit);
    pullup_fit = fit;
    srst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    srst = 1'b0;
    repeat (4) @(negedge clk);
    check(straps, fit);
    check({1'b0, engine}, {1'b0, fit[0], fit[0]});
    check(pulldown_en, 3'h0);
    check({2'h0, straps_valid}, 3'h1);
    last_fit = fit;
  endtask
  // Pin activity after the rise must leave the latch alone.
  task automatic t_hold(input logic [2:0] fit);
    pullup_fit = ~fit;
    repeat (20) @(negedge clk);
    check(straps, fit);
    check({1'b0, engine}, {1'b0, fit[0], fit[0]});
    check(pulldown_en, 3'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset for 20 cycles, then every fitting of the three straps.
  initial begin
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    t_reset();
    for (int i = 0; i < 8; i++) begin
      t_capture(3'(i));
      t_hold(3'(i));
    end
    t_reset_high(3'h5);
    end_of_test();
  end
endmodule
